// [logic/twsp_consts.vh]
// Purpose: constants for the two-wire register access slave
// Assumes: 10 MHz mclk, link sampled as ordinary inputs
// Notes:   definitions only
`ifndef TWSP_CONSTS_VH
`define TWSP_CONSTS_VH

`define TWSP_DEV_ADDR      7'h10
`define TWSP_INDEX_W       16
`define TWSP_DATA_W        8
`define TWSP_BITS_PER_BYTE 4'h8
`define TWSP_SYNC_STAGES   2
`define TWSP_INDEX_RESET   16'h0000

`endif

// [logic/twsp_sync.v]
// Purpose: two flip-flop synchroniser for one pin level
// Assumes: the input is asynchronous to mclk
// Notes:   the first stage is read only by the second
`timescale 1ns/1ps
`default_nettype none

module twsp_sync #(
	parameter RESET_VAL = 1'b1
) (
	input  wire mclk,
	input  wire resetn,
	input  wire pin_in,
	output reg  level_out
);

	// First stage, read only by the second stage
	reg meta_reg;

	// Two stages with constant reset value
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			meta_reg  <= RESET_VAL;
			level_out <= RESET_VAL;
		end else begin
			meta_reg  <= pin_in;
			level_out <= meta_reg;
		end
	end

endmodule

`default_nettype wire

// [logic/twsp_slave.v]
// Purpose: two-wire slave port giving a bus master access to 8-bit registers by 16-bit index
// Assumes: bus pins are sampled by mclk, which runs far faster than the link clock
// Notes:   register file access is a write strobe and a read-back data input
//          reg_rdata must follow reg_index without delay; it is sampled at
//          the clock fall that ends each acknowledge slot of a read, after
//          the index has stepped at the clock rise of that slot if the master acked
//
// Behaviour
// - Never hold clock low; purely passive
// - Only pull lines low, release for high
// - Respond only to address byte 0x20/0x21
// - Bytes MSB first, then one acknowledge bit
// - Sample data on rising clock edge
// - Detect start and stop conditions
// - Two bytes after address load index
// - Acknowledge matching address, store direction
// - Each index selects one 8-bit register
// - Written byte acknowledged, stored at index
// - Read byte parallel-loaded from index
// - Read bits change on falling clock edge
// - Slave acknowledges a matching address and every byte it receives after it; a master nack ends a read
// - Index increments after each written byte and each master-acked read byte
// - Full 16-bit index space reachable
// - Works without firmware or other interfaces
`timescale 1ns/1ps
`default_nettype none
`include "twsp_consts.vh"

module twsp_slave #(
	parameter INDEX_W = `TWSP_INDEX_W,
	parameter DATA_W  = `TWSP_DATA_W
) (
	input  wire               mclk,
	input  wire               resetn,
	input  wire               scl_in,
	input  wire               sda_in,
	output reg                sda_out,
	output reg                sda_oe,
	output reg                scl_out,
	output reg                scl_oe,
	output reg  [INDEX_W-1:0] reg_index,
	output reg  [DATA_W-1:0]  reg_wdata,
	output reg                reg_wr,
	output reg                reg_rd,
	input  wire [DATA_W-1:0]  reg_rdata,
	output reg                busy
);

	////////////////////////////////////////////////////////////////////////////
	// States, one-hot
	localparam [6:0] ST_IDLE = 7'h01; // Waiting for start
	localparam [6:0] ST_ADDR = 7'h02; // Receiving address byte
	localparam [6:0] ST_IDXH = 7'h04; // Receiving index high byte
	localparam [6:0] ST_IDXL = 7'h08; // Receiving index low byte
	localparam [6:0] ST_WDAT = 7'h10; // Receiving data bytes
	localparam [6:0] ST_RDAT = 7'h20; // Sending data bytes
	localparam [6:0] ST_ACK  = 7'h40; // Acknowledge slot

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	// Both pins pass two flip-flops, so the sequencer sees the bus two mclk
	// late; the link clock must stay low for about five mclk and high for about three.
	// Reset value is high, matching the pulled-up idle bus.
	wire scl_s;                         // Synchronised clock level
	wire sda_s;                         // Synchronised data level

	twsp_sync #(.RESET_VAL(1'b1)) u_scl_sync (
		.mclk      (mclk),
		.resetn    (resetn),
		.pin_in    (scl_in),
		.level_out (scl_s)
	);

	twsp_sync #(.RESET_VAL(1'b1)) u_sda_sync (
		.mclk      (mclk),
		.resetn    (resetn),
		.pin_in    (sda_in),
		.level_out (sda_s)
	);

	////////////////////////////////////////////////////////////////////////////
	// Edge and condition detection
	// Previous levels reset high like the idle bus, so release of reset
	// never shows a false edge, start or stop
	reg  scl_d_reg;                     // Previous clock level
	reg  sda_d_reg;                     // Previous data level
	wire scl_rise = scl_s & ~scl_d_reg; // Rising clock edge
	wire scl_fall = ~scl_s & scl_d_reg; // Falling clock edge
	wire start_c  = scl_s & scl_d_reg & sda_d_reg & ~sda_s; // Data falls, clock high
	wire stop_c   = scl_s & scl_d_reg & ~sda_d_reg & sda_s; // Data rises, clock high

	// Delayed copies of the synchronised levels
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Protocol state
	// ret_reg holds where to go once the acknowledge slot has ended
	reg [6:0]        state_reg;         // Current state
	reg [6:0]        ret_reg;           // State after acknowledge slot
	reg [3:0]        bit_cnt_reg;       // Bits received or sent in byte
	reg [DATA_W-1:0] shift_reg;         // Serial/parallel register
	reg              dir_rd_reg;        // Stored direction, 1 = read
	reg              ack_drive_reg;     // Slave drives acknowledge low
	reg              master_ack_reg;    // Master acknowledge sampled
	reg              wr_pend_reg;       // Byte to store at ack clock rise
	reg              inc_pend_reg;      // Index increment at ack end

	// Main sequencer, all on mclk with link edges as enables
	// Register accesses run wholly in this logic, no firmware
	// Start and stop take precedence over the bit logic, so a stop in
	// mid-byte discards the partial byte
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_reg      <= ST_IDLE;
			ret_reg        <= ST_IDLE;
			bit_cnt_reg    <= 4'h0;
			shift_reg      <= {DATA_W{1'b0}};
			dir_rd_reg     <= 1'b0;
			ack_drive_reg  <= 1'b0;
			master_ack_reg <= 1'b0;
			wr_pend_reg    <= 1'b0;
			inc_pend_reg   <= 1'b0;
			reg_index      <= `TWSP_INDEX_RESET;
			reg_wdata      <= {DATA_W{1'b0}};
			reg_wr         <= 1'b0;
			reg_rd         <= 1'b0;
			sda_out        <= 1'b0;
			sda_oe         <= 1'b0;
			scl_out        <= 1'b0;
			scl_oe         <= 1'b0;         // Clock line never driven
			busy           <= 1'b0;
		end else begin
			reg_wr <= 1'b0;
			reg_rd <= 1'b0;
			sda_out <= 1'b0;                // Only ever pulls low
			if (start_c) begin
				// Start or repeated start; index kept across messages
				// Bit count restarts; any partial byte is dropped
				state_reg     <= ST_ADDR;
				bit_cnt_reg   <= 4'h0;
				sda_oe        <= 1'b0;
				ack_drive_reg <= 1'b0;
				wr_pend_reg   <= 1'b0;
				inc_pend_reg  <= 1'b0;
				busy          <= 1'b1;
			end else if (stop_c) begin
				// Stop ends the message
				state_reg <= ST_IDLE;
				sda_oe    <= 1'b0;
				busy      <= 1'b0;
			end else begin
				case (state_reg)
					ST_IDLE: begin
						// Ignore bus until next start
						sda_oe <= 1'b0;
					end
					ST_ADDR, ST_IDXH, ST_IDXL, ST_WDAT: begin
						// Bits arrive on clock rise; the byte is judged at the fall
						// after the eighth bit, so the acknowledge starts with clock low
						if (scl_rise) begin
							// Shift in MSB first on rising edge
							shift_reg   <= {shift_reg[DATA_W-2:0], sda_s};
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
						end else if (scl_fall && bit_cnt_reg == `TWSP_BITS_PER_BYTE) begin
							bit_cnt_reg <= 4'h0;
							case (state_reg)
								ST_ADDR: begin
									if (shift_reg[7:1] == `TWSP_DEV_ADDR) begin
										// Match: acknowledge and store direction
										dir_rd_reg    <= shift_reg[0];
										ack_drive_reg <= 1'b1;
										sda_oe        <= 1'b1;
										state_reg     <= ST_ACK;
										if (shift_reg[0]) begin
											// Read: first byte comes from index
											ret_reg <= ST_RDAT;
											reg_rd  <= 1'b1;
										end else begin
											ret_reg <= ST_IDXH;
										end
									end else begin
										// No match: release line, go idle
										// Data stays released: no acknowledge for a foreign address
										state_reg <= ST_IDLE;
										busy      <= 1'b0;
									end
								end
								ST_IDXH: begin
									// Index high byte first
									reg_index[INDEX_W-1:8] <= shift_reg;
									ack_drive_reg <= 1'b1;
									sda_oe        <= 1'b1;
									ret_reg       <= ST_IDXL;
									state_reg     <= ST_ACK;
								end
								ST_IDXL: begin
									// Low byte completes the index; data bytes follow
									reg_index[7:0] <= shift_reg;
									ack_drive_reg  <= 1'b1;
									sda_oe         <= 1'b1;
									ret_reg        <= ST_WDAT;
									state_reg      <= ST_ACK;
								end
								default: begin
									// Data byte: acknowledge, then store
									reg_wdata     <= shift_reg;
									wr_pend_reg   <= 1'b1;
									ack_drive_reg <= 1'b1;
									sda_oe        <= 1'b1;
									ret_reg       <= ST_WDAT;
									state_reg     <= ST_ACK;
								end
							endcase
						end
					end
					ST_RDAT: begin
						// bit_cnt_reg counts bits already driven; the first one was
						// put out at the end of the preceding acknowledge slot
						if (scl_fall) begin
							if (bit_cnt_reg == `TWSP_BITS_PER_BYTE) begin
								// Byte sent; release for master acknowledge
								sda_oe        <= 1'b0;
								ack_drive_reg <= 1'b0;
								ret_reg       <= ST_RDAT;
								state_reg     <= ST_ACK;
								bit_cnt_reg   <= 4'h0;
							end else begin
								// Drive next bit on falling edge, MSB first
								sda_oe      <= ~shift_reg[DATA_W-1];
								shift_reg   <= {shift_reg[DATA_W-2:0], 1'b0};
								bit_cnt_reg <= bit_cnt_reg + 4'h1;
							end
						end
					end
					ST_ACK: begin
						// Acknowledge slot: the receiving side holds data for one clock period
						if (scl_rise) begin
							master_ack_reg <= ~sda_s;
							if (!ack_drive_reg && ret_reg == ST_RDAT && !sda_s) begin
								// Master acked a read byte: step the index now, so
								// that the next byte is fetched from it
								reg_index <= reg_index + 16'h0001;
							end
							if (ack_drive_reg && wr_pend_reg) begin
								// Store received byte at index
								reg_wr       <= 1'b1;
								wr_pend_reg  <= 1'b0;
								inc_pend_reg <= 1'b1;
							end
						end else if (scl_fall) begin
							sda_oe        <= 1'b0;
							ack_drive_reg <= 1'b0;
							if (inc_pend_reg) begin
								// Auto-increment after written byte
								reg_index    <= reg_index + 16'h0001;
								inc_pend_reg <= 1'b0;
							end
							if (ret_reg == ST_RDAT) begin
								if (dir_rd_reg && !ack_drive_reg && !master_ack_reg) begin
									// Master nack ends the read
									state_reg <= ST_IDLE;
									busy      <= 1'b0;
								end else begin
									// Load register, drive MSB now; reg_rdata already
									// follows the index, stepped at the clock rise if the master acked
									shift_reg   <= {reg_rdata[DATA_W-2:0], 1'b0};
									sda_oe      <= ~reg_rdata[DATA_W-1];
									bit_cnt_reg <= 4'h1;
									state_reg   <= ST_RDAT;
								end
							end else begin
								state_reg <= ret_reg;
							end
						end
					end
					default: begin
						// Illegal one-hot code: back to idle with data released
						state_reg <= ST_IDLE;
						sda_oe    <= 1'b0;
					end
				endcase
			end
		end
	end

endmodule

`default_nettype wire

// [dv/twras_chk.sv]
// Purpose: pin and strobe checks for the two-wire slave port
// Assumes: one domain, mclk, async active-low reset
// Notes:   bound into every slave instance
`timescale 1ns/1ps
`default_nettype none
module twras_chk #(
	parameter INDEX_W = 16
) (
	input wire logic               mclk,
	input wire logic               resetn,
	input wire logic               scl_in,
	input wire logic               sda_in,
	input wire logic               sda_out,
	input wire logic               sda_oe,
	input wire logic               scl_oe,
	input wire logic [INDEX_W-1:0] reg_index,
	input wire logic               reg_wr,
	input wire logic               reg_rd,
	input wire logic               busy
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	logic [INDEX_W-1:0] wr_idx_reg;  // Index at the last write strobe
	// Remember where the last byte went
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			wr_idx_reg <= '0;
		else if (reg_wr)
			wr_idx_reg <= reg_index;
	end
	AST_NO_STRETCH: assert property (!scl_oe)
		else $error("clock line pulled");
	AST_ONLY_LOW: assert property (sda_oe |-> !sda_out)
		else $error("data driven high");
	AST_WR_PULSE: assert property (reg_wr |=> !reg_wr)
		else $error("write strobe too long");
	AST_WR_IN_ACK: assert property (reg_wr |-> sda_oe && busy)
		else $error("write outside acknowledge");
	AST_IDX_STEP: assert property (reg_wr |-> ##[1:10] reg_index == wr_idx_reg + 1'b1)
		else $error("index not stepped");
	AST_IDX_KEPT: assert property (!busy && !$past(busy) |-> $stable(reg_index))
		else $error("index moved while idle");
	AST_SDA_ON_LOW: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("data changed with clock high");
	AST_START_BUSY: assert property (scl_in && $fell(sda_in) |-> ##[1:6] busy)
		else $error("start missed");
	AST_STOP_IDLE: assert property (scl_in && $rose(sda_in) |-> ##[1:6] !busy)
		else $error("stop missed");
	AST_RD_STROBE: assert property (reg_rd |-> (sda_oe && busy) ##1 !reg_rd)
		else $error("read strobe outside address acknowledge");
endmodule
bind twsp_slave twras_chk #(.INDEX_W(INDEX_W)) u_chk (.mclk, .resetn, .scl_in, .sda_in,
	.sda_out, .sda_oe, .scl_oe, .reg_index, .reg_wr, .reg_rd, .busy);
`default_nettype wire

// [dv/twras_master.sv]
// Purpose: far-side bus master model
// Assumes: 8 mclk a bit: clock low 5, high 3 (800 ns)
// Notes:   outputs mean pull the line low
`timescale 1ns/1ps
`default_nettype none
module twras_master (
	input  wire logic mclk,
	input  wire logic sda,
	output var  logic scl_low,
	output var  logic sda_low
);
	// Both lines released at time zero
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end
	// Wait n clock edges
	task automatic w(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// Start or repeated start: data falls while clock high
	task automatic start();
		w(2);
		sda_low <= 1'b0;
		w(3);
		scl_low <= 1'b0;
		w(2);
		sda_low <= 1'b1;
		w(2);
		scl_low <= 1'b1;
	endtask
	// Stop: data rises while clock high
	task automatic stop();
		w(2);
		sda_low <= 1'b1;
		w(3);
		scl_low <= 1'b0;
		w(2);
		sda_low <= 1'b0;
		w(4);
	endtask
	// One bit: data moves only while clock low
	task automatic bit_x(input logic b, output logic r);
		w(2);
		sda_low <= !b;
		w(3);
		scl_low <= 1'b0;
		w(2);
		r = sda;
		w(1);
		scl_low <= 1'b1;
	endtask
	// Byte MSB first, then the acknowledge slot
	task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q,
		output logic ao);
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], q[i]);
		bit_x(ai, ao);
	endtask
endmodule
`default_nettype wire

// [dv/test_two_wire_register_access_slave.sv]
// Purpose: self-checking bench for the two-wire slave port
// Assumes: 10 MHz mclk, master model on the link
// Notes:   register file and pull-ups live here
`timescale 1ns/1ps
`default_nettype none
module test_two_wire_register_access_slave;
	logic        mclk, resetn, scl_low, sda_low;
	logic        sda_out, sda_oe, scl_out, scl_oe, reg_wr, reg_rd, busy;
	logic [15:0] reg_index;
	logic [7:0]  reg_wdata;
	logic [7:0]  mem [0:65535];  // Register file
	logic [7:0]  exp_q [0:2];    // Bytes written this round
	int          fail_count, checks_done;
	// Pull-ups: low while any party pulls
	wire scl = !(scl_low || (scl_oe && !scl_out));
	wire sda = !(sda_low || (sda_oe && !sda_out));
	initial begin
		mclk = 1'b0;
		forever #50 mclk = !mclk;
	end
	// Strobed bytes land at the index
	always @(posedge mclk) begin
		if (reg_wr)
			mem[reg_index] <= reg_wdata;
	end
	twsp_slave u_dut (.mclk, .resetn, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe,
		.scl_out, .scl_oe, .reg_index, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata(mem[reg_index]), .busy);
	twras_master u_mst (.mclk, .sda, .scl_low, .sda_low);
	function automatic logic [15:0] idx_after(input logic [15:0] i, input int n);
		return i + 16'(n);
	endfunction
	task automatic check(input string s, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic send(input logic [7:0] d, input logic e);
		logic [7:0] q;
		logic a;
		u_mst.xfer(d, 1'b1, q, a);
		check("ack", {15'h0, e}, {15'h0, a});
	endtask
	task automatic report_and_stop();
		$display("mismatches %0d checks %0d", fail_count, checks_done);
		if (fail_count == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		int n;
		logic [15:0] idx;
		logic [7:0] q, bad;
		logic a;
		resetn = 1'b0;
		fail_count = 0;
		checks_done = 0;
		foreach (mem[i]) mem[i] = 8'h00;
		void'($urandom(32'hFFF1C276));
		repeat (4) @(posedge mclk);
		check("reset index", 16'h0000, reg_index);
		resetn <= 1'b1;
		repeat (3) @(posedge mclk);
		for (int r = 0; r < 4; r++) begin
			idx = (r == 0) ? 16'hFFFF : 16'($urandom);
			n = (r == 0) ? 3 : 1 + $urandom % 3;
			u_mst.start();
			send(8'h20, 1'b0);
			send(idx[15:8], 1'b0);
			send(idx[7:0], 1'b0);
			for (int i = 0; i < n; i++) begin
				exp_q[i] = 8'($urandom);
				send(exp_q[i], 1'b0);
			end
			u_mst.stop();
			check("write index", idx_after(idx, n), reg_index);
			check("busy", 16'h0000, {15'h0, busy});
			u_mst.start();
			send(8'h20, 1'b0);
			send(idx[15:8], 1'b0);
			send(idx[7:0], 1'b0);
			u_mst.start();
			send(8'h21, 1'b0);
			for (int i = 0; i < n; i++) begin
				u_mst.xfer(8'hFF, i == n - 1, q, a);
				check("read byte", {8'h00, exp_q[i]}, {8'h00, q});
			end
			u_mst.stop();
			check("read index", idx_after(idx, n - 1), reg_index);
			bad = 8'($urandom);
			if (bad[7:1] == 7'h10)
				bad = bad ^ 8'h80;
			u_mst.start();
			send(bad, 1'b1);
			send(8'h00, 1'b1);
			u_mst.stop();
			check("foreign index", idx_after(idx, n - 1), reg_index);
		end
		report_and_stop();
	end
	// Hang guard
	initial begin
		repeat (100000) @(posedge mclk);
		fail_count++;
		report_and_stop();
	end
endmodule
`default_nettype wire
